// file: hdl/flash_seq_pkg.sv
// flash power-mode and restart sequencing: shared constants and types
// assumes a 20 MHz reference clock on both ends of the link
package flash_seq_pkg;

	// ----------------------------------------------------------------
	// reference clock and conversion helpers
	// ----------------------------------------------------------------
	localparam int REF_PERIOD_NS = 50;

	// least time: round up, never below one cycle
	function automatic int ceil_cyc(input int ns);
		int c;
		c = (ns + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction : ceil_cyc

	// longest time: round down, never below one cycle
	function automatic int floor_cyc(input int ns);
		int c;
		c = ns / REF_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction : floor_cyc

	// ----------------------------------------------------------------
	// sequencing times
	// ----------------------------------------------------------------
	localparam int POWER_UP_DELAY_NS = 300000;
	localparam int RESTART_RECOVERY_TIME_NS = 35000;
	localparam int RESTART_PULSE_WIDTH_NS = 200;
	localparam int RESTART_SETUP_TIME_NS = 50;
	localparam int RESTART_HOLD_TIME_NS = 50;
	localparam int DESELECT_TIME_READ_NS = 10;
	localparam int DESELECT_TIME_PROG_NS = 50;

	localparam int POWER_UP_CYC_DEF = floor_cyc(POWER_UP_DELAY_NS);
	localparam int RECOVERY_CYC = ceil_cyc(RESTART_RECOVERY_TIME_NS);
	localparam int PULSE_CYC = ceil_cyc(RESTART_PULSE_WIDTH_NS);
	localparam int SETUP_CYC = ceil_cyc(RESTART_SETUP_TIME_NS);
	localparam int HOLD_CYC = ceil_cyc(RESTART_HOLD_TIME_NS);
	localparam int DESEL_READ_CYC = ceil_cyc(DESELECT_TIME_READ_NS);
	localparam int DESEL_PROG_CYC = ceil_cyc(DESELECT_TIME_PROG_NS);

	// ----------------------------------------------------------------
	// serial clock ceilings per command class, in MHz
	// ----------------------------------------------------------------
	localparam int SCK_MAX_BASIC_READ_MHZ = 50;
	localparam int SCK_MAX_SINGLE_MHZ = 133;
	localparam int SCK_MAX_MULTI_READ_MHZ = 104;
	localparam int SCK_MAX_QUAD_PROG_MHZ = 80;

	typedef enum logic [1:0] {
		CLS_BASIC_READ,
		CLS_SINGLE,
		CLS_MULTI_READ,
		CLS_QUAD_PROG
	} cmd_class_e;

	// ----------------------------------------------------------------
	// opcodes the device model acts on
	// ----------------------------------------------------------------
	localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
	localparam logic [7:0] OP_SECTOR_ERASE = 8'hd8;
	localparam int OP_CYC_DEF = 16;

	// status bits returned on the data-out line
	localparam int STAT_BUSY_BIT = 6;
	localparam int STAT_WEL_BIT = 5;

endpackage : flash_seq_pkg

// file: hdl/flash_link_if.sv
// serial link between host controller and flash device
// assumes the host drives clock, select, restart and data-in
`timescale 1ns/100ps
`default_nettype none
interface flash_link_if;
	logic sclk;
	logic sel_n;
	logic restart_n;
	logic mosi;
	logic miso_o;
	logic miso_oe;
	logic miso;

	// undriven data-out line floats high
	assign miso = miso_oe ? miso_o : 1'b1;

	modport dev (
		input sclk,
		input sel_n,
		input restart_n,
		input mosi,
		output miso_o,
		output miso_oe
	);

	modport host (
		output sclk,
		output sel_n,
		output restart_n,
		output mosi,
		input miso
	);
endinterface : flash_link_if
`default_nettype wire

// file: hdl/flash_dev_end.sv
// flash device end: power modes, power-on and restart sequencing
// assumes the link clock stops outside frames; timers run on ref_clk_i
`timescale 1ns/100ps
`default_nettype none
module flash_dev_end #(
	parameter int POWER_UP_CYC = flash_seq_pkg::POWER_UP_CYC_DEF,
	parameter int OP_CYC = flash_seq_pkg::OP_CYC_DEF,
	parameter int TMR_W = 13
) (
	// clock, reset, enable
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	// power-on fault strap
	input wire logic por_fault_i,
	// serial link
	flash_link_if.dev link,
	// device status
	output logic ready_o,
	output logic active_o,
	output logic standby_o,
	output logic busy_o,
	output logic wel_o,
	output logic por_ok_o
);
	import flash_seq_pkg::*;

	typedef enum logic [1:0] {
		D_POR,
		D_HELD,
		D_READY,
		D_RECOV
	} dev_state_e;

	localparam logic [TMR_W-1:0] PU_LOAD = TMR_W'(POWER_UP_CYC - 1);
	// pin sync (2) and pulse filter (PULSE_CYC + 1) already eat into recovery
	localparam logic [TMR_W-1:0] RPH_LOAD = TMR_W'(RECOVERY_CYC - PULSE_CYC - 3);
	localparam logic [TMR_W-1:0] OP_LOAD = TMR_W'(OP_CYC - 1);
	localparam logic [7:0] RP_LAST = 8'(PULSE_CYC - 1);
	localparam logic [3:0] SYNC_RST = 4'h3;

	function automatic logic is_prog_op(input logic [7:0] op);
		return (op == OP_PAGE_PROGRAM) || (op == OP_SECTOR_ERASE);
	endfunction : is_prog_op

	// ----------------------------------------------------------------
	// link domain: command shift-in, frame ended by select high
	// ----------------------------------------------------------------
	logic link_rstn;
	logic [3:0] bitcnt_r;
	logic [6:0] shift_r;
	logic [7:0] cmd_byte_r;
	logic cmd_tgl_r;
	logic [2:0] stat_l1_r;
	logic [2:0] stat_l2_r;
	logic miso_r;
	logic miso_oe_r;
	logic [2:0] stat_ref;
	logic miso_nxt;

	assign link_rstn = rstn_i & ~link.sel_n;

	always_ff @(posedge link.sclk or negedge link_rstn)
	begin
		if (!link_rstn) begin
			bitcnt_r <= 4'h0;
			shift_r <= 7'h00;
		end else begin
			bitcnt_r <= bitcnt_r + 4'h1;
			shift_r <= {shift_r[5:0], link.mosi};
		end
	end

	always_ff @(posedge link.sclk or negedge rstn_i)
	begin
		if (!rstn_i) begin
			cmd_byte_r <= 8'h00;
			cmd_tgl_r <= 1'b0;
		end else if (bitcnt_r == 4'h7 && stat_l2_r[2]) begin
			cmd_byte_r <= {shift_r, link.mosi};
			cmd_tgl_r <= ~cmd_tgl_r;
		end
	end

	// status levels into link domain
	always_ff @(posedge link.sclk or negedge rstn_i)
	begin
		if (!rstn_i) begin
			stat_l1_r <= 3'h0;
			stat_l2_r <= 3'h0;
		end else begin
			stat_l1_r <= stat_ref;
			stat_l2_r <= stat_l1_r;
		end
	end

	assign miso_nxt = (bitcnt_r == 4'h1) ? stat_l2_r[1] :
		(bitcnt_r == 4'h2) ? stat_l2_r[0] : 1'b0;

	always_ff @(negedge link.sclk or negedge link_rstn)
	begin
		if (!link_rstn) begin
			miso_r <= 1'b0;
			miso_oe_r <= 1'b0;
		end else begin
			miso_r <= miso_nxt;
			miso_oe_r <= stat_l2_r[2];
		end
	end

	assign link.miso_o = miso_r;
	assign link.miso_oe = miso_oe_r;

	// ----------------------------------------------------------------
	// reference domain: pin synchronisers
	// ----------------------------------------------------------------
	logic [3:0] sync1_r;
	logic [3:0] sync2_r;
	logic tgl_prev_r;
	logic rst_prev_r;
	logic sel_lo;
	logic rst_lo;
	logic cmd_evt;
	logic rst_fall;
	logic fault_s;

	always_ff @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i) begin
			sync1_r <= SYNC_RST;
			sync2_r <= SYNC_RST;
			tgl_prev_r <= 1'b0;
			rst_prev_r <= 1'b1;
		end else if (ce_i) begin
			sync1_r <= {por_fault_i, cmd_tgl_r, link.restart_n, link.sel_n};
			sync2_r <= sync1_r;
			tgl_prev_r <= sync2_r[2];
			rst_prev_r <= sync2_r[1];
		end
	end

	assign sel_lo = ~sync2_r[0];
	assign rst_lo = ~sync2_r[1];
	assign cmd_evt = sync2_r[2] ^ tgl_prev_r;
	assign rst_fall = rst_prev_r & rst_lo;
	assign fault_s = sync2_r[3];

	// ----------------------------------------------------------------
	// reference domain: sequencing state machine
	// ----------------------------------------------------------------
	dev_state_e st_r;
	dev_state_e st_nxt;
	logic [TMR_W-1:0] tmr_r;
	logic [TMR_W-1:0] tmr_nxt;
	logic [TMR_W-1:0] opc_r;
	logic [TMR_W-1:0] opc_nxt;
	logic [7:0] low_r;
	logic [7:0] low_nxt;
	logic wel_r;
	logic wel_nxt;
	logic busy_r;
	logic busy_nxt;
	logic por_ok_r;
	logic por_ok_nxt;
	logic ready_r;
	logic active_r;
	logic standby_r;
	logic low_long;

	assign low_long = rst_lo && (low_r == RP_LAST);
	assign low_nxt = (!rst_lo) ? 8'h00 : (low_long ? low_r : low_r + 8'h01);
	assign stat_ref = {ready_r, busy_r, wel_r};

	always_comb
	begin
		st_nxt = st_r;
		tmr_nxt = tmr_r;
		opc_nxt = opc_r;
		wel_nxt = wel_r;
		busy_nxt = busy_r;
		por_ok_nxt = por_ok_r;
		if (busy_r) begin
			if (opc_r == '0) begin
				busy_nxt = 1'b0;
				wel_nxt = 1'b0;
			end else begin
				opc_nxt = opc_r - 1'b1;
			end
		end
		case (st_r)
			D_POR:
			begin
				// restart pin looked at only once the delay ends
				if (tmr_r == '0) begin
					por_ok_nxt = ~fault_s;
					wel_nxt = 1'b0;
					busy_nxt = 1'b0;
					// held low at end keeps reset
					st_nxt = rst_lo ? D_HELD : D_READY;
				end else begin
					tmr_nxt = tmr_r - 1'b1;
				end
			end
			D_HELD:
			begin
				if (!rst_lo) begin
					st_nxt = D_READY;
				end
			end
			D_READY:
			begin
				if (rst_fall && !por_ok_r) begin
					st_nxt = D_POR;
					tmr_nxt = PU_LOAD;
					wel_nxt = 1'b0;
					busy_nxt = 1'b0;
				end else if (low_long) begin
					st_nxt = D_RECOV;
					tmr_nxt = RPH_LOAD;
					wel_nxt = 1'b0;
					busy_nxt = 1'b0;
				end else if (cmd_evt) begin
					if (cmd_byte_r == OP_WRITE_ENABLE) begin
						wel_nxt = 1'b1;
					end else if (cmd_byte_r == OP_WRITE_DISABLE && !busy_r) begin
						wel_nxt = 1'b0;
					end else if (is_prog_op(cmd_byte_r) && wel_r && !busy_r) begin
						busy_nxt = 1'b1;
						opc_nxt = OP_LOAD;
					end
				end
			end
			D_RECOV:
			begin
				// interface back to standby after recovery
				if (tmr_r != '0) begin
					tmr_nxt = tmr_r - 1'b1;
				end else if (!rst_lo) begin
					st_nxt = D_READY;
				end
			end
			default:
			begin
				st_nxt = D_POR;
				tmr_nxt = PU_LOAD;
			end
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i) begin
			st_r <= D_POR;
			tmr_r <= PU_LOAD;
			opc_r <= '0;
			low_r <= 8'h00;
			wel_r <= 1'b0;
			busy_r <= 1'b0;
			por_ok_r <= 1'b0;
		end else if (ce_i) begin
			st_r <= st_nxt;
			tmr_r <= tmr_nxt;
			opc_r <= opc_nxt;
			low_r <= low_nxt;
			wel_r <= wel_nxt;
			busy_r <= busy_nxt;
			por_ok_r <= por_ok_nxt;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i) begin
			ready_r <= 1'b0;
			active_r <= 1'b0;
			standby_r <= 1'b0;
		end else if (ce_i) begin
			ready_r <= (st_nxt == D_READY);
			active_r <= sel_lo | busy_nxt;
			standby_r <= ~(sel_lo | busy_nxt) & (st_nxt == D_READY);
		end
	end

	assign ready_o = ready_r;
	assign active_o = active_r;
	assign standby_o = standby_r;
	assign busy_o = busy_r;
	assign wel_o = wel_r;
	assign por_ok_o = por_ok_r;

endmodule : flash_dev_end
`default_nettype wire

// file: hdl/flash_host_end.sv
// host controller end: paces power-up, restart and one-byte commands
// assumes the device end samples data-in on rising serial clock
`timescale 1ns/100ps
`default_nettype none
module flash_host_end #(
	parameter int POWER_UP_CYC = flash_seq_pkg::POWER_UP_CYC_DEF,
	parameter int PULSE_CYC_P = flash_seq_pkg::PULSE_CYC,
	parameter int SCK_HALF = 4,
	parameter int TMR_W = 13
) (
	// clock, reset, enable
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	// command request
	input wire logic cmd_valid_i,
	input wire logic [7:0] cmd_opcode_i,
	input wire flash_seq_pkg::cmd_class_e cmd_class_i,
	input wire logic cmd_prog_i,
	input wire logic restart_req_i,
	output logic cmd_ready_o,
	// command answer
	output logic done_o,
	output logic [7:0] status_o,
	// serial link
	flash_link_if.host link
);
	import flash_seq_pkg::*;

	typedef enum logic [2:0] {
		H_PWRUP,
		H_IDLE,
		H_RST_LOW,
		H_RST_HOLD,
		H_SEL,
		H_SHIFT,
		H_DESEL
	} host_state_e;

	function automatic int max2(input int a, input int b);
		return (a > b) ? a : b;
	endfunction : max2

	// least half period for a clock ceiling in MHz
	function automatic int half_cyc(input int mhz);
		return ceil_cyc((1000 + 2 * mhz - 1) / (2 * mhz));
	endfunction : half_cyc

	localparam logic [TMR_W-1:0] PU_LOAD = TMR_W'(POWER_UP_CYC - 1);
	localparam logic [TMR_W-1:0] RP_LOAD = TMR_W'(PULSE_CYC_P - 1);
	localparam logic [TMR_W-1:0] RH_LOAD = TMR_W'(max2(HOLD_CYC, RECOVERY_CYC - PULSE_CYC_P) - 1);
	localparam logic [TMR_W-1:0] DR_LOAD = TMR_W'(DESEL_READ_CYC - 1);
	localparam logic [TMR_W-1:0] DP_LOAD = TMR_W'(DESEL_PROG_CYC - 1);
	localparam logic [7:0] RS_LAST = 8'(SETUP_CYC);

	// ----------------------------------------------------------------
	// data-out synchroniser and setup counter
	// ----------------------------------------------------------------
	logic miso_s1_r;
	logic miso_s2_r;
	logic [7:0] rs_r;
	logic rs_ok;
	logic [7:0] half_lim;

	assign half_lim = (cmd_class_i == CLS_BASIC_READ) ? 8'(max2(SCK_HALF, half_cyc(SCK_MAX_BASIC_READ_MHZ))) :
		(cmd_class_i == CLS_SINGLE) ? 8'(max2(SCK_HALF, half_cyc(SCK_MAX_SINGLE_MHZ))) :
		(cmd_class_i == CLS_MULTI_READ) ? 8'(max2(SCK_HALF, half_cyc(SCK_MAX_MULTI_READ_MHZ))) :
		8'(max2(SCK_HALF, half_cyc(SCK_MAX_QUAD_PROG_MHZ)));
	assign rs_ok = (rs_r == RS_LAST);

	// ----------------------------------------------------------------
	// sequencing state machine
	// ----------------------------------------------------------------
	host_state_e st_r;
	host_state_e st_nxt;
	logic [TMR_W-1:0] tmr_r;
	logic [TMR_W-1:0] tmr_nxt;
	logic [7:0] half_r;
	logic [7:0] half_nxt;
	logic [7:0] hlim_r;
	logic [7:0] hlim_nxt;
	logic [3:0] bits_r;
	logic [3:0] bits_nxt;
	logic [7:0] tx_r;
	logic [7:0] tx_nxt;
	logic [7:0] rx_r;
	logic [7:0] rx_nxt;
	logic prog_r;
	logic prog_nxt;
	logic sclk_r;
	logic sclk_nxt;
	logic sel_n_r;
	logic sel_n_nxt;
	logic rpin_r;
	logic rpin_nxt;
	logic done_nxt;
	logic done_r;
	logic [7:0] status_r;
	logic ready_r;

	always_comb
	begin
		st_nxt = st_r;
		tmr_nxt = tmr_r;
		half_nxt = half_r;
		hlim_nxt = hlim_r;
		bits_nxt = bits_r;
		tx_nxt = tx_r;
		rx_nxt = rx_r;
		prog_nxt = prog_r;
		sclk_nxt = sclk_r;
		sel_n_nxt = sel_n_r;
		rpin_nxt = rpin_r;
		done_nxt = 1'b0;
		case (st_r)
			H_PWRUP:
			begin
				if (tmr_r == '0) begin
					st_nxt = H_IDLE;
				end else begin
					tmr_nxt = tmr_r - 1'b1;
				end
			end
			H_IDLE:
			begin
				if (restart_req_i && ready_r && rs_ok) begin
					st_nxt = H_RST_LOW;
					rpin_nxt = 1'b0;
					tmr_nxt = RP_LOAD;
				end else if (cmd_valid_i && ready_r) begin
					st_nxt = H_SEL;
					sel_n_nxt = 1'b0;
					tx_nxt = cmd_opcode_i;
					prog_nxt = cmd_prog_i;
					hlim_nxt = half_lim;
					bits_nxt = 4'h0;
					half_nxt = 8'h00;
				end
			end
			H_RST_LOW:
			begin
				if (tmr_r == '0) begin
					st_nxt = H_RST_HOLD;
					rpin_nxt = 1'b1;
					tmr_nxt = RH_LOAD;
				end else begin
					tmr_nxt = tmr_r - 1'b1;
				end
			end
			H_RST_HOLD:
			begin
				// select stays high until hold ends
				if (tmr_r == '0) begin
					st_nxt = H_IDLE;
				end else begin
					tmr_nxt = tmr_r - 1'b1;
				end
			end
			H_SEL:
			begin
				st_nxt = H_SHIFT;
			end
			H_SHIFT:
			begin
				if (half_r == hlim_r - 8'h01) begin
					half_nxt = 8'h00;
					if (!sclk_r) begin
						sclk_nxt = 1'b1;
						rx_nxt = {rx_r[6:0], miso_s2_r};
						bits_nxt = bits_r + 4'h1;
					end else begin
						sclk_nxt = 1'b0;
						tx_nxt = {tx_r[6:0], 1'b0};
						if (bits_r == 4'h8) begin
							st_nxt = H_DESEL;
							sel_n_nxt = 1'b1;
							tmr_nxt = prog_r ? DP_LOAD : DR_LOAD;
						end
					end
				end else begin
					half_nxt = half_r + 8'h01;
				end
			end
			H_DESEL:
			begin
				if (tmr_r == '0) begin
					st_nxt = H_IDLE;
					done_nxt = 1'b1;
				end else begin
					tmr_nxt = tmr_r - 1'b1;
				end
			end
			default:
			begin
				st_nxt = H_PWRUP;
				tmr_nxt = PU_LOAD;
			end
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i) begin
			st_r <= H_PWRUP;
			tmr_r <= PU_LOAD;
			half_r <= 8'h00;
			hlim_r <= 8'h01;
			bits_r <= 4'h0;
			tx_r <= 8'h00;
			rx_r <= 8'h00;
			prog_r <= 1'b0;
		end else if (ce_i) begin
			st_r <= st_nxt;
			tmr_r <= tmr_nxt;
			half_r <= half_nxt;
			hlim_r <= hlim_nxt;
			bits_r <= bits_nxt;
			tx_r <= tx_nxt;
			rx_r <= rx_nxt;
			prog_r <= prog_nxt;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i) begin
			sclk_r <= 1'b0;
			sel_n_r <= 1'b1;
			rpin_r <= 1'b1;
			done_r <= 1'b0;
			status_r <= 8'h00;
			ready_r <= 1'b0;
			miso_s1_r <= 1'b1;
			miso_s2_r <= 1'b1;
			rs_r <= 8'h00;
		end else if (ce_i) begin
			sclk_r <= sclk_nxt;
			sel_n_r <= sel_n_nxt;
			rpin_r <= rpin_nxt;
			done_r <= done_nxt;
			status_r <= done_nxt ? rx_r : status_r;
			ready_r <= (st_nxt == H_IDLE);
			miso_s1_r <= link.miso;
			miso_s2_r <= miso_s1_r;
			rs_r <= !rpin_r ? 8'h00 : (rs_ok ? rs_r : rs_r + 8'h01);
		end
	end

	assign link.sclk = sclk_r;
	assign link.sel_n = sel_n_r;
	assign link.restart_n = rpin_r;
	assign link.mosi = tx_r[7];
	assign cmd_ready_o = ready_r;
	assign done_o = done_r;
	assign status_o = status_r;

endmodule : flash_host_end
`default_nettype wire

// file: sim/flash_link_sva.sv
// checker: link-level sequencing of select, restart and data-out enable
// assumes instantiation beside the link interface, ref clock domain
`timescale 1ns/100ps
`default_nettype none
module flash_link_sva
	import flash_seq_pkg::*;
#(
	parameter int POWER_UP_CYC = POWER_UP_CYC_DEF
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	// link
	input wire logic sclk,
	input wire logic sel_n,
	input wire logic restart_n,
	input wire logic miso_oe
);
	// ----------------------------------------------------------------
	// cycles since reset release and since restart pin low
	// ----------------------------------------------------------------
	logic [15:0] up_cnt_r;
	logic [15:0] rs_cnt_r;
	logic rs_prev_r;
	wire logic [15:0] up_cnt_nxt = (&up_cnt_r) ? up_cnt_r : up_cnt_r + 16'h0001;
	wire logic [15:0] rs_inc = (&rs_cnt_r) ? rs_cnt_r : rs_cnt_r + 16'h0001;
	wire logic [15:0] rs_cnt_nxt = (rs_prev_r && !restart_n) ? 16'h0000 : rs_inc;

	always_ff @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			up_cnt_r <= 16'h0000;
			rs_cnt_r <= 16'hffff;
			rs_prev_r <= 1'b1;
		end
		else
		begin
			up_cnt_r <= up_cnt_nxt;
			rs_cnt_r <= rs_cnt_nxt;
			rs_prev_r <= restart_n;
		end
	end

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rstn_i);

	a_oe_desel: assert property (sel_n ##1 sel_n |-> !miso_oe)
		else $error("data out driven while deselected");
	a_pwrup_sel: assert property ($fell(sel_n) |-> up_cnt_r >= POWER_UP_CYC)
		else $error("select low before power-up delay");
	a_rst_cover: assert property ($fell(sel_n) |-> rs_cnt_r >= RECOVERY_CYC)
		else $error("select low before restart recovery");
	a_rst_sel: assert property (!restart_n |-> sel_n)
		else $error("select low during restart pulse");
	a_pulse_width: assert property ($fell(restart_n) |-> !restart_n [*4] ##1 restart_n)
		else $error("restart pulse width wrong");
	a_rst_setup: assert property ($fell(restart_n) |->
		up_cnt_r >= POWER_UP_CYC + SETUP_CYC && rs_cnt_r >= RECOVERY_CYC + SETUP_CYC)
		else $error("restart issued too early");
	a_recov_tri: assert property (rs_cnt_r < RECOVERY_CYC |-> !miso_oe)
		else $error("data out driven during recovery");
	a_desel_gap: assert property ($rose(sel_n) |=> sel_n)
		else $error("deselect gap too short");
	a_sclk_idle: assert property (sel_n |-> !sclk)
		else $error("serial clock high while deselected");
	a_sck_rate: assert property ($changed(sclk) |=> $stable(sclk) [*3])
		else $error("serial clock half period too short");
endmodule : flash_link_sva
`default_nettype wire

// file: sim/testbench.sv
// testbench: host and device ends joined by the link interface
// assumes both ends built with POWER_UP_CYC 50
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import flash_seq_pkg::*;
	logic clk, rstn, ce, por_fault, cmd_valid, cmd_prog, rs_req;
	logic [7:0] cmd_op, mon;
	cmd_class_e cmd_cls;
	logic cmd_ready, done, ready, active, standby, busy, write_enable_latch, por_ok;
	logic [7:0] status;
	int miscompares, n_checks, n;
	wire logic [7:0] flags = {2'h0, ready, active, standby, busy, write_enable_latch, por_ok};

	flash_link_if link_bus();
	flash_dev_end #(.POWER_UP_CYC(50), .OP_CYC(40)) u_flash_dev_end (.ref_clk_i(clk),
		.rstn_i(rstn), .ce_i(ce), .por_fault_i(por_fault), .link(link_bus.dev),
		.ready_o(ready), .active_o(active), .standby_o(standby), .busy_o(busy),
		.wel_o(write_enable_latch), .por_ok_o(por_ok));
	flash_host_end #(.POWER_UP_CYC(50)) u_flash_host_end (.ref_clk_i(clk), .rstn_i(rstn),
		.ce_i(ce), .cmd_valid_i(cmd_valid), .cmd_opcode_i(cmd_op), .cmd_class_i(cmd_cls),
		.cmd_prog_i(cmd_prog), .restart_req_i(rs_req), .cmd_ready_o(cmd_ready),
		.done_o(done), .status_o(status), .link(link_bus.host));
	flash_link_sva #(.POWER_UP_CYC(50)) u_sva (.ref_clk_i(clk), .rstn_i(rstn),
		.sclk(link_bus.sclk), .sel_n(link_bus.sel_n), .restart_n(link_bus.restart_n),
		.miso_oe(link_bus.miso_oe));

	// ----------------------------------------------------------------
	// clock, wire monitor, helpers
	// ----------------------------------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	always @(posedge link_bus.sclk)
		if (link_bus.sel_n === 1'b0)
			mon <= {mon[6:0], link_bus.mosi};

	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
		n_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("BAD %0t %s: %h expected %h", $time, msg, seen, exp);
		end
	endtask : check

	task automatic idle(input int c);
		repeat (c) @(posedge clk);
		#2;
	endtask : idle

	task automatic wait_ready(output int c);
		c = 0;
		while (ready !== 1'b1 && c < 1000)
		begin
			idle(1);
			c++;
		end
	endtask : wait_ready

	task automatic request(input logic [7:0] op, input logic prog, input cmd_class_e cls,
		input logic rs);
		int k;
		k = 0;
		while (cmd_ready !== 1'b1 && k < 2000)
		begin
			idle(1);
			k++;
		end
		cmd_op = op;
		cmd_prog = prog;
		cmd_cls = cls;
		cmd_valid = !rs;
		rs_req = rs;
		idle(1);
		cmd_valid = 1'b0;
		rs_req = 1'b0;
		k = 0;
		while (!rs && done !== 1'b1 && k < 200)
		begin
			idle(1);
			k++;
		end
		if (!rs)
		begin
			check({7'h0, done}, 8'h01, "done pulse");
			check(mon, op, "opcode on wire");
		end
	endtask : request

	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : finish_test

	initial
	begin
		#1000000;
		miscompares++;
		finish_test();
	end

	// ----------------------------------------------------------------
	// test sequence
	// ----------------------------------------------------------------
	initial
	begin
		{rstn, por_fault, cmd_valid, cmd_prog, rs_req, cmd_op} = '0;
		ce = 1'b1;
		cmd_cls = CLS_SINGLE;
		idle(4);
		check(flags, 8'h00, "reset flags");
		check({5'h0, link_bus.sel_n, link_bus.restart_n, link_bus.sclk}, 8'h06, "idle link");
		rstn = 1'b1;
		wait_ready(n);
		check({7'h0, n <= 60}, 8'h01, "power-up delay");
		check(flags, 8'h29, "after power-up");
		request(OP_WRITE_ENABLE, 1'b0, CLS_SINGLE, 1'b0);
		idle(4);
		check(flags, 8'h2b, "write enable");
		for (int c = 0; c < 4; c++)
		begin
			request(8'h05, 1'b0, cmd_class_e'(c), 1'b0);
			check({1'b0, status[6:0]}, 8'h20, "status per class");
		end
		request(OP_PAGE_PROGRAM, 1'b1, CLS_QUAD_PROG, 1'b0);
		idle(4);
		check(flags, 8'h37, "busy while deselected");
		ce = 1'b0;
		idle(60);
		check(flags, 8'h37, "frozen while enable low");
		ce = 1'b1;
		n = 0;
		while (busy !== 1'b0 && n < 100)
		begin
			idle(1);
			n++;
		end
		check(flags, 8'h29, "standby after program");
		request(OP_SECTOR_ERASE, 1'b1, CLS_SINGLE, 1'b0);
		idle(4);
		check(flags, 8'h29, "erase without enable");
		request(OP_WRITE_ENABLE, 1'b0, CLS_SINGLE, 1'b0);
		request(OP_SECTOR_ERASE, 1'b1, CLS_SINGLE, 1'b0);
		request(8'h00, 1'b0, CLS_SINGLE, 1'b1);
		idle(12);
		check(flags, 8'h01, "abort on restart");
		wait_ready(n);
		check({7'h0, n >= 680 && n <= 720}, 8'h01, "recovery length");
		check(flags, 8'h29, "standby after recovery");
		request(OP_WRITE_ENABLE, 1'b0, CLS_SINGLE, 1'b0);
		idle(4);
		check(flags, 8'h2b, "command after recovery");
		request(OP_WRITE_DISABLE, 1'b0, CLS_SINGLE, 1'b0);
		idle(4);
		check(flags, 8'h29, "write disable");
		rstn = 1'b0;
		por_fault = 1'b1;
		idle(4);
		rstn = 1'b1;
		idle(58);
		check({7'h0, por_ok}, 8'h00, "failed power-on");
		por_fault = 1'b0;
		request(8'h00, 1'b0, CLS_SINGLE, 1'b1);
		idle(12);
		wait_ready(n);
		check({7'h0, n >= 30 && n <= 100}, 8'h01, "full power-on rerun");
		check(flags, 8'h29, "after rerun");
		finish_test();
	end
endmodule : testbench
`default_nettype wire
